// *** hw/pie_chan_mem.sv ***
`timescale 1ns/1ps
module pie_chan_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 60
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  pie_mem_if.mem port
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rd_q;

  // Contents are not reset: software configures a channel before use
  always_ff @(posedge sys_clk)
  begin
    if (port.wr_en)
    begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_q <= '0;
    end
    else if (port.rd_en)
    begin
      rd_q <= mem_q[port.rd_addr];
    end
  end

  assign port.rd_data = rd_q;

endmodule // pie_chan_mem

// *** hw/pie_ctrl_top.sv ***
// Functional notes
// - Interrupt entry follows the decision by 7 clocks with jump cache, else 11.
// - Each node is routed either to the vectored controller or to a channel.
// - A channel service steals one cycle and never enters a service routine.
// - A service moves one byte or word and steps the pointers as configured.
// - Every service decrements the channel counter except in continuous mode.
// - A channel whose counter is zero raises the node's standard interrupt.
// - Eight channels each hold their own pointers and transfer counter.
// - Every node has a control word with request, enable and priority.
// - Each node may be set to one of sixteen priority levels.
// - A node preempts the running service level only with a strictly higher priority; a trap is taken at any level.
// - Each node branches to its own dedicated vector.
// - Fast inputs detect rising, falling or both edges as configured.
// - A trap request carries a number that selects its vector.
// - Software setting a node request flag raises that node's request.
`timescale 1ns/1ps
module pie_ctrl_top
  import pie_pkg::*;
#(
  parameter int NODES = PIE_NODES,
  parameter int CHANNELS = PIE_CHANNELS,
  parameter int FAST_IN = PIE_FAST_IN,
  parameter int NIW = $clog2(NODES)
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [NODES-1:0] periph_req,
  input wire logic [FAST_IN-1:0] ext_irq_pin,
  input wire pie_edge_t [FAST_IN-1:0] ext_edge_sel,
  input wire logic node_wr_en,
  input wire logic [NIW-1:0] node_wr_idx,
  input wire logic [CTL_W-1:0] node_wr_data,
  input wire logic [NIW-1:0] node_rd_idx,
  output logic [CTL_W-1:0] node_rd_data_q,
  output logic [NODES-1:0] node_request_flag_q,
  input wire logic ch_wr_en,
  input wire logic [CH_SEL_W-1:0] ch_wr_idx,
  input wire pie_chan_t ch_wr_data,
  input wire logic jump_cache_en,
  input wire logic trap_valid,
  input wire logic [TRAP_W-1:0] trap_num,
  input wire logic cpu_ret,
  input wire logic [PRIO_W-1:0] cpu_ret_level,
  output logic cpu_int_entry_q,
  output logic [VEC_W-1:0] cpu_int_vector_q,
  output logic [PRIO_W-1:0] cpu_int_level_q,
  output logic cpu_steal_q,
  output logic xfer_valid,
  input wire logic xfer_ready,
  output logic [ADDR_W-1:0] xfer_src,
  output logic [ADDR_W-1:0] xfer_dst,
  output logic xfer_word
);

  localparam int CHW = $bits(pie_chan_t);
  localparam int XW = $bits(pie_xfer_t);

  pie_mem_if #(.AW(CH_SEL_W), .DW(CHW)) chm ();
  pie_stream_if #(.W(XW)) xin ();
  pie_stream_if #(.W(XW)) xout ();

  pie_state_t st_q, st_d;
  logic [RESP_W-1:0] cnt_q, cnt_d;
  logic [NIW-1:0] sel_node_q;
  logic [PRIO_W-1:0] sel_prio_q;
  logic [CH_SEL_W-1:0] sel_ch_q;
  logic sel_trap_q;
  logic [TRAP_W-1:0] sel_trapnum_q;
  logic trap_pend_q;
  logic [TRAP_W-1:0] trap_num_q;
  logic [FAST_IN-1:0] ext_s1_q, ext_s2_q, ext_s3_q;
  logic [CTL_W-1:0] ctl_q [NODES];

  // Pins pass two flops against metastability; a third gives the edge
  wire [FAST_IN-1:0] ext_rise = ext_s2_q & ~ext_s3_q;
  wire [FAST_IN-1:0] ext_fall = ~ext_s2_q & ext_s3_q;

  wire [NODES-1:0] hw_set;
  wire [NODES-1:0] clr_node;
  wire [PRIO_W-1:0] best_p [NODES+1];
  wire [NIW-1:0] best_i [NODES+1];
  assign best_p[0] = PRIO_NEVER;
  assign best_i[0] = '0;

  wire [FAST_IN-1:0] ext_hit;
  for (genvar f = 0; f < FAST_IN; f++)
  begin : g_fast
    assign ext_hit[f] =
      ((ext_edge_sel[f] == EDGE_RISE) && ext_rise[f]) ||
      ((ext_edge_sel[f] == EDGE_FALL) && ext_fall[f]) ||
      ((ext_edge_sel[f] == EDGE_BOTH) && (ext_rise[f] || ext_fall[f]));
  end
  assign hw_set = periph_req | NODES'(ext_hit);

  for (genvar g = 0; g < NODES; g++)
  begin : g_node
    wire wr_me = node_wr_en && (node_wr_idx == NIW'(g));
    wire [PRIO_W-1:0] prio = ctl_q[g][CTL_PRIO_LSB +: PRIO_W];
    // Hardware set wins over the acceptance clear and over software
    wire req_d = (wr_me ? node_wr_data[CTL_REQ_BIT]
                        : (ctl_q[g][CTL_REQ_BIT] && !clr_node[g]))
                 || hw_set[g];
    wire cand = ctl_q[g][CTL_REQ_BIT] && ctl_q[g][CTL_EN_BIT] &&
                (prio != PRIO_NEVER);
    // Strict compare: the lower node index wins a tie
    assign best_p[g+1] = (cand && prio > best_p[g]) ? prio : best_p[g];
    assign best_i[g+1] = (cand && prio > best_p[g]) ? NIW'(g) : best_i[g];
    assign node_request_flag_q[g] = ctl_q[g][CTL_REQ_BIT];

    always_ff @(posedge sys_clk)
    begin
      if (sys_rst)
        ctl_q[g] <= CTL_RESET;
      else
      begin
        if (wr_me)
          ctl_q[g] <= node_wr_data;
        ctl_q[g][CTL_REQ_BIT] <= req_d;
      end
    end
  end

  wire [PRIO_W-1:0] win_prio = best_p[NODES];
  wire [NIW-1:0] win_node = best_i[NODES];
  wire [CTL_W-1:0] win_ctl = ctl_q[win_node];
  wire win_chen = win_ctl[CTL_CHEN_BIT];
  wire [CH_SEL_W-1:0] win_ch = win_ctl[CTL_CHSEL_LSB +: CH_SEL_W];
  wire win_ok = win_prio > cpu_int_level_q;
  wire idle = (st_q == ST_IDLE);
  wire go_trap = idle && trap_pend_q;
  wire go_node = idle && !trap_pend_q && win_ok;
  wire go_chan = go_node && win_chen;

  pie_chan_t chd;
  assign chd = pie_chan_t'(chm.rd_data);
  wire in_ch = (st_q == ST_CH);
  wire ch_zero = (chd.cnt == '0);
  wire start_wait = go_trap || (go_node && !win_chen) ||
                    (in_ch && ch_zero);
  wire entry_d = (st_q == ST_WAIT) && (cnt_q == '0);
  wire push = xin.valid && xin.ready;

  wire [ADDR_W-1:0] step = chd.word ? WORD_STEP : BYTE_STEP;
  pie_chan_t ch_next;
  assign ch_next.src = chd.src + (chd.inc_src ? step : NO_STEP);
  assign ch_next.dst = chd.dst + (chd.inc_dst ? step : NO_STEP);
  assign ch_next.cnt = chd.cont ? chd.cnt : chd.cnt - CNT_ONE;
  assign {ch_next.inc_src, ch_next.inc_dst, ch_next.word, ch_next.cont} =
    {chd.inc_src, chd.inc_dst, chd.word, chd.cont};

  // Write-back owns the port; a same-cycle software write is dropped
  assign chm.wr_en = push || ch_wr_en;
  assign chm.wr_addr = push ? sel_ch_q : ch_wr_idx;
  assign chm.wr_data = push ? ch_next : ch_wr_data;
  assign chm.rd_en = go_chan;
  assign chm.rd_addr = win_ch;

  assign xin.valid = in_ch && !ch_zero;
  assign xin.data = {chd.src, chd.dst, chd.word};

  wire [NODES-1:0] sel_onehot = NODES'(1) << sel_node_q;
  assign clr_node = (push || (entry_d && !sel_trap_q)) ? sel_onehot : '0;

  wire [TRAP_W-1:0] node_trap = NODE_TRAP_BASE + TRAP_W'(sel_node_q);
  wire [VEC_W-1:0] vec_d = sel_trap_q ? VEC_W'({sel_trapnum_q, VEC_PAD})
                                      : VEC_W'({node_trap, VEC_PAD});
  wire [RESP_W-1:0] resp_load = jump_cache_en ? RESP_CACHE_LOAD
                                              : RESP_NOCACHE_LOAD;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:
        if (go_trap || (go_node && !win_chen))
          st_d = ST_WAIT;
        else if (go_chan)
          st_d = ST_CH;
      ST_WAIT:
        if (entry_d)
          st_d = ST_IDLE;
      ST_CH:
        if (ch_zero)
          st_d = ST_WAIT;
        else if (push)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  assign cnt_d = start_wait ? resp_load
               : ((st_q == ST_WAIT && cnt_q != '0) ? cnt_q - RESP_ONE
                                                   : cnt_q);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sel_node_q <= '0;
      sel_prio_q <= PRIO_NEVER;
      sel_ch_q <= '0;
      sel_trap_q <= 1'b0;
      sel_trapnum_q <= '0;
      trap_pend_q <= 1'b0;
      trap_num_q <= '0;
      cpu_int_entry_q <= 1'b0;
      cpu_int_vector_q <= '0;
      cpu_int_level_q <= PRIO_NEVER;
      cpu_steal_q <= 1'b0;
      node_rd_data_q <= CTL_RESET;
      {ext_s3_q, ext_s2_q, ext_s1_q} <= '0;
    end
    else
    begin
      {ext_s3_q, ext_s2_q, ext_s1_q} <= {ext_s2_q, ext_s1_q, ext_irq_pin};
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (idle)
      begin
        sel_node_q <= win_node;
        sel_prio_q <= win_prio;
        sel_ch_q <= win_ch;
        sel_trap_q <= trap_pend_q;
        sel_trapnum_q <= trap_num_q;
      end
      trap_pend_q <= trap_valid || (trap_pend_q && !(entry_d && sel_trap_q));
      if (trap_valid)
        trap_num_q <= trap_num;
      cpu_int_entry_q <= entry_d;
      if (entry_d)
        cpu_int_vector_q <= vec_d;
      if (entry_d && !sel_trap_q)
        cpu_int_level_q <= sel_prio_q;
      else if (cpu_ret)
        cpu_int_level_q <= cpu_ret_level;
      cpu_steal_q <= push;
      node_rd_data_q <= ctl_q[node_rd_idx];
    end
  end

  pie_chan_mem #(.DEPTH(CHANNELS), .AW(CH_SEL_W), .DW(CHW)) u_mem (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .port(chm)
  );

  pie_skid_buf #(.W(XW)) u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_s(xin),
    .out_s(xout)
  );

  assign xout.ready = xfer_ready;
  assign xfer_valid = xout.valid;
  assign {xfer_src, xfer_dst, xfer_word} = xout.data;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_resp_cache;
    start_wait && jump_cache_en |->
      ##1 !cpu_int_entry_q [*6] ##1 cpu_int_entry_q;
  endproperty
  a_resp_cache: assert property (p_resp_cache)
    else $error("entry not 7 clocks after decision");

  property p_resp_nocache;
    start_wait && !jump_cache_en |->
      ##1 !cpu_int_entry_q [*8] ##1 !cpu_int_entry_q [*2] ##1 cpu_int_entry_q;
  endproperty
  a_resp_nocache: assert property (p_resp_nocache)
    else $error("entry not 11 clocks after decision");

  property p_steal_one;
    cpu_steal_q |-> !cpu_int_entry_q ##1 !cpu_steal_q;
  endproperty
  a_steal_one: assert property (p_steal_one)
    else $error("steal longer than one cycle");

  property p_zero_no_move;
    in_ch && ch_zero |-> !push ##1 (st_q == ST_WAIT);
  endproperty
  a_zero_no_move: assert property (p_zero_no_move)
    else $error("zero count channel moved data");

  property p_count;
    push |-> (chm.wr_data[CNT_W+3:4] ==
              (chd.cont ? chd.cnt : chd.cnt - CNT_ONE));
  endproperty
  a_count: assert property (p_count)
    else $error("channel count not updated");

  property p_preempt;
    idle && !trap_pend_q && (win_prio <= cpu_int_level_q) |=>
      (st_q == ST_IDLE);
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("accepted request not of higher priority");

  property p_clear;
    cpu_int_entry_q && !sel_trap_q && !$past(node_wr_en) &&
      !$past(hw_set[sel_node_q]) |-> !node_request_flag_q[sel_node_q];
  endproperty
  a_clear: assert property (p_clear)
    else $error("request flag not cleared on acceptance");

  property p_edge0;
    (ext_edge_sel[0] == EDGE_RISE) && ext_rise[0] |=> node_request_flag_q[0];
  endproperty
  a_edge0: assert property (p_edge0)
    else $error("rising edge did not set request");

  property p_vector;
    cpu_int_entry_q && !sel_trap_q |->
      cpu_int_vector_q == VEC_W'({node_trap, VEC_PAD});
  endproperty
  a_vector: assert property (p_vector)
    else $error("node vector wrong");

  property p_trap_vec;
    cpu_int_entry_q && sel_trap_q |->
      cpu_int_vector_q == VEC_W'({sel_trapnum_q, VEC_PAD});
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector wrong");

  c_steal: cover property (cpu_steal_q);
  c_entry: cover property (cpu_int_entry_q && !sel_trap_q);
  c_zero: cover property (in_ch && ch_zero);
  c_full: cover property (xin.valid && !xin.ready);

endmodule // pie_ctrl_top

// *** hw/pie_if.sv ***
`timescale 1ns/1ps
interface pie_mem_if #(parameter int AW = 3, parameter int DW = 60);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
               output rd_data);
endinterface // pie_mem_if

interface pie_stream_if #(parameter int W = 49);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, data, input ready);
  modport snk (input valid, data, output ready);
endinterface // pie_stream_if

// *** hw/pie_pkg.sv ***
package pie_pkg;

  localparam int PIE_NODES = 16;
  localparam int PIE_CHANNELS = 8;
  localparam int PIE_FAST_IN = 4;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 8;
  localparam int PRIO_W = 4;
  localparam int VEC_W = 16;
  localparam int TRAP_W = 8;
  localparam int RESP_W = 4;

  // Node control word layout
  localparam int CTL_REQ_BIT = 0;
  localparam int CTL_EN_BIT = 1;
  localparam int CTL_PRIO_LSB = 2;
  localparam int CTL_CHEN_BIT = 6;
  localparam int CTL_CHSEL_LSB = 7;
  localparam int CH_SEL_W = 3;
  localparam int CTL_W = 10;
  localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;

  localparam logic [PRIO_W-1:0] PRIO_NEVER = 4'h0;
  localparam logic [TRAP_W-1:0] NODE_TRAP_BASE = 8'h10;
  localparam logic [1:0] VEC_PAD = 2'h0;

  // Response latency in CPU clocks, and the counter load that yields it
  localparam int RESP_CACHE_CLKS = 7;
  localparam int RESP_NOCACHE_CLKS = 11;
  localparam logic [RESP_W-1:0] RESP_CACHE_LOAD = RESP_W'(RESP_CACHE_CLKS - 2);
  localparam logic [RESP_W-1:0] RESP_NOCACHE_LOAD =
    RESP_W'(RESP_NOCACHE_CLKS - 2);
  localparam logic [RESP_W-1:0] RESP_ONE = 4'h1;

  localparam logic [ADDR_W-1:0] BYTE_STEP = 24'h000001;
  localparam logic [ADDR_W-1:0] WORD_STEP = 24'h000002;
  localparam logic [ADDR_W-1:0] NO_STEP = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH}
    pie_edge_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CH} pie_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [CNT_W-1:0] cnt;
    logic inc_src;
    logic inc_dst;
    logic word;
    logic cont;
  } pie_chan_t;

  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic word;
  } pie_xfer_t;

endpackage

// *** hw/pie_skid_buf.sv ***
`timescale 1ns/1ps
module pie_skid_buf #(
  parameter int W = 49
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  pie_stream_if.snk in_s,
  pie_stream_if.src out_s
);

  logic [W-1:0] head_q;
  logic [W-1:0] skid_q;
  logic head_v_q;
  logic skid_v_q;

  wire push = in_s.valid && !skid_v_q;
  wire head_free = !head_v_q || out_s.ready;

  // Ready comes from a flop so the source never sees a combinational path
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      head_q <= '0;
      skid_q <= '0;
    end
    else if (head_free)
    begin
      head_v_q <= skid_v_q || push;
      head_q <= skid_v_q ? skid_q : in_s.data;
      skid_v_q <= 1'b0;
    end
    else if (push)
    begin
      skid_v_q <= 1'b1;
      skid_q <= in_s.data;
    end
  end

  assign in_s.ready = !skid_v_q;
  assign out_s.valid = head_v_q;
  assign out_s.data = head_q;

endmodule // pie_skid_buf

// *** tb/pie_xfer_sink.sv ***
`timescale 1ns/1ps
module pie_xfer_sink
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [ADDR_W-1:0] xfer_src,
  input wire logic [ADDR_W-1:0] xfer_dst,
  input wire logic xfer_word
);
  pie_xfer_t got_q[$];
  // A stalled receiver forces the buffer to hold up to two pending words
  assign xfer_ready = !stall;
  always @(posedge sys_clk)
  begin
    if (!sys_rst && xfer_valid === 1'b1 && xfer_ready)
    begin
      got_q.push_back('{xfer_src, xfer_dst, xfer_word});
    end
  end
endmodule // pie_xfer_sink

// *** tb/tb_priority_interrupt_event_ctrl.sv ***
`timescale 1ns/1ps
module tb_priority_interrupt_event_ctrl
  import pie_pkg::*;
;
  logic sys_clk, sys_rst, node_wr_en, ch_wr_en, jump_cache_en, trap_valid;
  logic cpu_ret, stall, cpu_int_entry_q, cpu_steal_q;
  logic xfer_valid, xfer_ready, xfer_word;
  logic [15:0] periph_req, node_request_flag_q;
  logic [3:0] ext_irq_pin, node_wr_idx, node_rd_idx, cpu_ret_level;
  pie_edge_t [3:0] ext_edge_sel;
  logic [CTL_W-1:0] node_wr_data, node_rd_data_q;
  logic [2:0] ch_wr_idx;
  pie_chan_t ch_wr_data;
  logic [7:0] trap_num;
  logic [VEC_W-1:0] cpu_int_vector_q;
  logic [PRIO_W-1:0] cpu_int_level_q;
  logic [ADDR_W-1:0] xfer_src, xfer_dst;
  int bad_count, num_checks, cycles, entries, steals, n, n_c;
  pie_xfer_t x;

  pie_ctrl_top dut (
    .sys_clk, .sys_rst, .periph_req, .ext_irq_pin, .ext_edge_sel,
    .node_wr_en, .node_wr_idx, .node_wr_data, .node_rd_idx,
    .node_rd_data_q, .node_request_flag_q, .ch_wr_en, .ch_wr_idx,
    .ch_wr_data, .jump_cache_en, .trap_valid, .trap_num, .cpu_ret,
    .cpu_ret_level, .cpu_int_entry_q, .cpu_int_vector_q,
    .cpu_int_level_q, .cpu_steal_q, .xfer_valid, .xfer_ready,
    .xfer_src, .xfer_dst, .xfer_word
  );

  pie_xfer_sink snk (
    .sys_clk, .sys_rst, .stall, .xfer_valid, .xfer_ready, .xfer_src,
    .xfer_dst, .xfer_word
  );

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [CTL_W-1:0] ctl(input logic [3:0] p,
    input logic en, input logic req, input logic chen, input logic [2:0] c);
    return {c, chen, p, en, req};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp,
    input string msg);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // Strobe tasks end one edge after release so back-to-back calls never
  // assign the strobe twice in one time step
  task automatic wr_node(input logic [3:0] i, input logic [CTL_W-1:0] d);
    node_wr_en <= 1'b1;
    node_wr_idx <= i;
    node_wr_data <= d;
    @(posedge sys_clk);
    node_wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr_ch(input logic [2:0] i, input pie_chan_t d);
    ch_wr_en <= 1'b1;
    ch_wr_idx <= i;
    ch_wr_data <= d;
    @(posedge sys_clk);
    ch_wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic ret0();
    cpu_ret <= 1'b1;
    cpu_ret_level <= 4'h0;
    @(posedge sys_clk);
    cpu_ret <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_entry(input int lim, output int c);
    c = -1;
    for (int i = 1; i <= lim; i++)
    begin
      @(posedge sys_clk);
      if (cpu_int_entry_q === 1'b1)
      begin
        c = i;
        break;
      end
    end
  endtask

  task automatic pop_xfer(input logic [ADDR_W-1:0] s,
    input logic [ADDR_W-1:0] d, input logic w);
    if (snk.got_q.size() == 0)
      check(64'h0, 64'h1, "missing transfer");
    else
    begin
      x = snk.got_q.pop_front();
      check({x.src, x.dst, x.word}, {s, d, w}, "transfer");
    end
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cpu_int_entry_q === 1'b1)
      entries <= entries + 1;
    if (cpu_steal_q === 1'b1)
      steals <= steals + 1;
    if (cycles == 4000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    {sys_clk, node_wr_en, ch_wr_en, trap_valid, cpu_ret, stall} = '0;
    {periph_req, ext_irq_pin, node_wr_idx, cpu_ret_level, trap_num} = '0;
    {node_wr_data, ch_wr_idx, ch_wr_data} = '0;
    ext_edge_sel = '0;
    node_rd_idx = 4'hD;
    jump_cache_en = 1'b1;
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check({cpu_int_level_q, node_request_flag_q, xfer_valid}, 0, "reset");
    for (int p = 0; p < 16; p++)
    begin
      wr_node(4'hD, ctl(p[3:0], 1'b0, p[0], 1'b1, 3'h5));
      @(posedge sys_clk);
      check(node_rd_data_q, {3'h5, 1'b1, p[3:0], 1'b0, p[0]}, "ctl");
    end
    wr_node(4'hD, 0);
    wr_node(4'h3, ctl(4'h5, 1'b1, 1'b1, 1'b0, 3'h0));
    wait_entry(40, n_c);
    check(n_c, 7, "latency with cache");
    check(cpu_int_vector_q, 16'h004C, "vector");
    check(cpu_int_level_q, 4'h5, "level");
    @(posedge sys_clk);
    check(node_request_flag_q[3], 1'b0, "flag kept");
    ret0();
    jump_cache_en <= 1'b0;
    wr_node(4'h3, ctl(4'h5, 1'b1, 1'b1, 1'b0, 3'h0));
    wait_entry(40, n);
    check(n, 11, "latency without cache");
    check(n - n_c, 4, "latency gap");
    ret0();
    jump_cache_en <= 1'b1;
    wr_node(4'h2, ctl(4'h5, 1'b1, 1'b1, 1'b0, 3'h0));
    wait_entry(40, n);
    wr_node(4'h4, ctl(4'h5, 1'b1, 1'b1, 1'b0, 3'h0));
    wait_entry(30, n);
    check(n == -1, 1'b1, "equal level preempted");
    wr_node(4'h7, ctl(4'h6, 1'b1, 1'b1, 1'b0, 3'h0));
    wait_entry(40, n);
    check({cpu_int_vector_q, cpu_int_level_q}, 20'h005C6, "preempt");
    ret0();
    wait_entry(40, n);
    check(cpu_int_vector_q, 16'h0050, "pending after return");
    ret0();
    wr_node(4'h6, ctl(4'h0, 1'b1, 1'b1, 1'b0, 3'h0));
    wr_node(4'h8, ctl(4'h9, 1'b0, 1'b1, 1'b0, 3'h0));
    wait_entry(30, n);
    check(n == -1, 1'b1, "level zero or disabled served");
    wr_node(4'h6, 0);
    wr_node(4'h8, 0);
    wr_node(4'hB, ctl(4'h3, 1'b1, 1'b0, 1'b0, 3'h0));
    periph_req[11] <= 1'b1;
    @(posedge sys_clk);
    periph_req[11] <= 1'b0;
    wait_entry(40, n);
    check(cpu_int_vector_q, 16'h006C, "hardware request");
    ret0();
    trap_valid <= 1'b1;
    trap_num <= 8'h2A;
    @(posedge sys_clk);
    trap_valid <= 1'b0;
    wait_entry(40, n);
    check({cpu_int_vector_q, cpu_int_level_q}, 20'h00A80, "trap");
    for (int m = 0; m < 4; m++)
    begin
      wr_node(m[3:0], 0);
      ext_edge_sel[m] <= pie_edge_t'(m[1:0] ^ 2'h1);
      ext_irq_pin[m] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check(node_request_flag_q[m], !m[0], "rising edge");
      wr_node(m[3:0], 0);
      ext_irq_pin[m] <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check(node_request_flag_q[m], m[1], "falling edge");
    end
    stall <= 1'b1;
    wr_ch(3'h2, '{24'h000100, 24'h000200, 8'h02, 1'b1, 1'b1, 1'b1, 1'b0});
    n_c = entries;
    n = steals;
    repeat (2)
    begin
      wr_node(4'h9, ctl(4'h4, 1'b1, 1'b1, 1'b1, 3'h2));
      repeat (12) @(posedge sys_clk);
    end
    check(steals - n, 2, "steal count");
    check(entries - n_c, 0, "channel entered routine");
    stall <= 1'b0;
    repeat (8) @(posedge sys_clk);
    pop_xfer(24'h000100, 24'h000200, 1'b1);
    pop_xfer(24'h000102, 24'h000202, 1'b1);
    wr_node(4'h9, ctl(4'h4, 1'b1, 1'b1, 1'b1, 3'h2));
    wait_entry(40, n);
    check(cpu_int_vector_q, 16'h0064, "count exhausted");
    ret0();
    stall <= 1'b1;
    wr_ch(3'h7, '{24'h000300, 24'h000400, 8'h01, 1'b1, 1'b0, 1'b0, 1'b1});
    n_c = entries;
    n = steals;
    repeat (3)
    begin
      wr_node(4'hA, ctl(4'h2, 1'b1, 1'b1, 1'b1, 3'h7));
      repeat (12) @(posedge sys_clk);
    end
    check(steals - n, 2, "full buffer accepted more");
    stall <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check(steals - n, 3, "steal after drain");
    check(entries - n_c, 0, "continuous mode interrupted");
    pop_xfer(24'h000300, 24'h000400, 1'b0);
    pop_xfer(24'h000301, 24'h000400, 1'b0);
    pop_xfer(24'h000302, 24'h000400, 1'b0);
    check(snk.got_q.size(), 0, "extra transfers");
    stop_test();
  end
endmodule // tb_priority_interrupt_event_ctrl
